// ---- dv/tb.sv ----
// Purpose: self-checking bench for the reference rate register bank
// Assumes: byte register port, read data one cycle after the strobe
// Notes:   a shadow byte image predicts every read and every level output
`timescale 1ns/100ps

module tb;
   logic               i_ref_clk = 1'b0;
   logic               i_rst_b   = 1'b0;
   logic [7:0]         i_addr    = 8'h00;
   logic [7:0]         i_wdata   = 8'h00;
   logic               i_wr      = 1'b0;
   logic               i_rd      = 1'b0;
   logic [7:0]         o_rdata;
   rfc_pkg::rfc_rate_t o_input2_rate;
   logic [15:0]        o_input3_base_rate;
   logic [79:0]        mdl; // bytes 0x20..0x29, lowest address at the top
   int                 failures    = 0;
   int                 comparisons = 0;

   rfc_ref_rate_regs dut_u (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_input2_rate(o_input2_rate),
      .o_input3_base_rate(o_input3_base_rate));

   // ***************************************************************
   // clock, checks and closing
   // ***************************************************************
   always #25 i_ref_clk = ~i_ref_clk;

   task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // expected read byte; unmapped places read as zero
   function automatic logic [7:0] exp_rd(input logic [7:0] a);
      return (a >= 8'h20 && a <= 8'h29) ? mdl[79 - 8 * (a - 8'h20) -: 8] : 8'h00;
   endfunction

   // expected reference frequency from the four fields
   function automatic logic [63:0] ref_hz(input logic [63:0] v);
      return (64'(v[63:48]) * 64'(v[47:32]) * 64'(v[31:16])) / 64'(v[15:0]);
   endfunction

   task automatic chk_out();
      check("input2_rate", o_input2_rate, mdl[79:16]);
      check("input3_base", o_input3_base_rate, mdl[15:0]);
   endtask

   // ***************************************************************
   // bus cycles
   // ***************************************************************
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
      if (a >= 8'h20 && a <= 8'h29) mdl[79 - 8 * (a - 8'h20) -: 8] = d;
      #1 chk_out(); // each byte lands alone, one cycle after
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1 check("rdata", o_rdata, exp_rd(a));
      @(posedge i_ref_clk);
      #1 check("rdata_idle", o_rdata, 8'h00); // data stands one cycle only
   endtask

   // ***************************************************************
   // main sequence
   // ***************************************************************
   logic [63:0] fec_set [2] = '{64'h9C40_0F30_00FF_00ED, 64'h61A8_186A_41BE_3B80};
   logic [63:0] fec_hz [2] = '{64'd167331645, 64'd172642299};
   logic [63:0] plain_set [2] = '{64'h1F40_0100_0001_0001, 64'h9C40_01E6_0001_0001};
   logic [63:0] plain_hz [2] = '{64'd2048000, 64'd19440000};
   logic [15:0] rates [9] = '{16'h03E8, 16'h07D0, 16'h1388, 16'h186A, 16'h1F40, 16'h2710, 16'h30D4, 16'h61A8,
      16'h9C40};

   initial begin
      mdl = 80'h9C40_01E6_0001_0001_9C40;
      void'($urandom(93727));
      repeat (6) @(posedge i_ref_clk);
      i_rst_b <= 1'b1;
      chk_out();
      for (int a = 8'h1E; a <= 8'h2B; a++) rd(a[7:0]);
      $display("test reset_values done");
      // high byte at the lower address, partial update visible
      foreach (fec_set[s]) begin
         for (int b = 0; b < 8; b++) wr(8'h20 + b[7:0], fec_set[s][63 - 8 * b -: 8]);
         check("fec_ref_hz", ref_hz(o_input2_rate), fec_hz[s]);
      end
      $display("test fec_examples done");
      foreach (plain_set[s]) begin
         for (int b = 0; b < 8; b++) wr(8'h20 + b[7:0], plain_set[s][63 - 8 * b -: 8]);
         check("plain_ref_hz", ref_hz(o_input2_rate), plain_hz[s]);
      end
      $display("test plain_rates done");
      foreach (rates[r]) begin
         wr(8'h20, rates[r][15:8]);
         wr(8'h21, rates[r][7:0]);
         wr(8'h28, rates[r][15:8]);
         wr(8'h29, rates[r][7:0]);
         rd(8'h20);
      end
      $display("test base_rates done");
      // random traffic, unmapped neighbours included
      repeat (300) begin
         if ($urandom % 2) wr(8'h1C + 8'($urandom % 18), 8'($urandom));
         else rd(($urandom % 8 == 0) ? 8'($urandom) : 8'h1C + 8'($urandom % 18));
      end
      $display("test random_traffic done");
      // reset in mid-run restores every default at once
      @(posedge i_ref_clk);
      i_rst_b <= 1'b0;
      mdl = 80'h9C40_01E6_0001_0001_9C40;
      @(posedge i_ref_clk);
      #1 chk_out();
      check("rdata_in_reset", o_rdata, 8'h00);
      @(posedge i_ref_clk);
      i_rst_b <= 1'b1;
      rd(8'h24);
      $display("test mid_reset done");
      final_report();
   end

   // watchdog at 20000 cycles, far beyond the thousand or so cycles the tests need
   initial begin
      #(20000 * 50);
      failures++;
      final_report();
   end
endmodule // tb

// ---- rtl/rfc_consts.svh ----
// Purpose: offsets, field positions and reset values of the reference rate bank
// Assumes: byte-wide register port, big-endian multi-byte registers
// Notes:   byte addresses; each wide register spans consecutive bytes
`ifndef RFC_CONSTS_SVH
`define RFC_CONSTS_SVH

// ***************************************************************
// byte offsets
// ***************************************************************
`define RFC_OFS_IN2_BASE    8'h20
`define RFC_OFS_IN2_MULT    8'h22
`define RFC_OFS_IN2_FEC     8'h24
`define RFC_OFS_IN3_BASE    8'h28

// ***************************************************************
// field positions of the fec ratio register
// ***************************************************************
`define RFC_FEC_DEN_LSB     0
`define RFC_FEC_NUM_LSB     16

// ***************************************************************
// reset values
// ***************************************************************
`define RFC_RST_BASE        16'h9C40
`define RFC_RST_MULT        16'h01E6
`define RFC_RST_FEC         32'h00010001

`endif

// ---- rtl/rfc_pkg.sv ----
// Purpose: types shared by the reference rate bank and its users
// Assumes: nothing beyond the constants header
// Notes:   the rate struct is the carrier toward monitoring and pll logic
package rfc_pkg;

   // ***************************************************************
   // register port request
   // ***************************************************************
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } rfc_req_t;

   // ***************************************************************
   // frequency parameters of one reference input
   // ***************************************************************
   typedef struct packed {
      logic [15:0] input_base_rate_hz;
      logic [15:0] base_rate_multiplier;
      logic [15:0] fec_ratio_numerator;
      logic [15:0] fec_ratio_denominator;
   } rfc_rate_t;

endpackage

// ---- rtl/rfc_ref_rate_regs.sv ----
// Purpose: byte-addressed configuration bank for reference input frequencies
// Assumes: single 20 MHz clock, port inputs synchronous to it
// Notes:   big-endian byte layout; read data valid one cycle after strobe
//
// How it works
// - second input base rate in hertz
// - most significant byte at lower address
// - multiplier is unsigned base rate scale
// - denominator low half, numerator high half
// - frequency is base times multiplier times ratio
`timescale 1ns/100ps
`include "rfc_consts.svh"

module rfc_ref_rate_regs (
   input  wire logic             i_ref_clk,
   input  wire logic             i_rst_b,
   input  wire logic [7:0]       i_addr,
   input  wire logic [7:0]       i_wdata,
   input  wire logic             i_wr,
   input  wire logic             i_rd,
   output logic [7:0]            o_rdata,
   output rfc_pkg::rfc_rate_t    o_input2_rate,
   output logic [15:0]           o_input3_base_rate
);

   // ***************************************************************
   // storage: ten bytes, index = offset from first register
   // ***************************************************************
   localparam int NBYTE = 10;

   logic [7:0]        byte_r [NBYTE];
   rfc_pkg::rfc_req_t req;
   logic [7:0]        rdata_nxt;

   assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

   // map address to byte index; out-of-bank gives NBYTE
   function automatic logic [3:0] byte_index(input logic [7:0] a);
      logic [7:0] d;
      d = a - `RFC_OFS_IN2_BASE;
      if (a >= `RFC_OFS_IN2_BASE && d < 8'(NBYTE)) begin
         byte_index = d[3:0];
      end else begin
         byte_index = 4'(NBYTE);
      end
   endfunction

   // reset value of each byte, big-endian split of the wide defaults
   function automatic logic [7:0] byte_reset(input int i);
      logic [15:0] base;
      logic [15:0] mult;
      logic [31:0] fec;
      base = `RFC_RST_BASE;
      mult = `RFC_RST_MULT;
      fec  = `RFC_RST_FEC;
      case (i)
         0, 8:    byte_reset = base[15:8];
         1, 9:    byte_reset = base[7:0];
         2:       byte_reset = mult[15:8];
         3:       byte_reset = mult[7:0];
         4:       byte_reset = fec[31:24];
         5:       byte_reset = fec[23:16];
         6:       byte_reset = fec[15:8];
         7:       byte_reset = fec[7:0];
         default: byte_reset = 8'h00;
      endcase
   endfunction

   // ***************************************************************
   // byte write; offsets 0x26..0x27 hold fec low bytes, 0x28..0x29 input3
   // ***************************************************************
   genvar g;
   generate
      for (g = 0; g < NBYTE; g++) begin : g_byte
         always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
               byte_r[g] <= byte_reset(g);
            end else if (req.wr && byte_index(req.addr) == 4'(g)) begin
               byte_r[g] <= req.wdata;
            end
         end
      end
   endgenerate

   // ***************************************************************
   // read path: unmapped addresses read zero
   // ***************************************************************
   always_comb begin
      logic [3:0] idx;
      idx = byte_index(req.addr);
      rdata_nxt = 8'h00;
      if (req.rd && idx < 4'(NBYTE)) begin
         rdata_nxt = byte_r[idx];
      end
   end

   // data stands only in the cycle after the read strobe
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rdata <= 8'h00;
      end else begin
         o_rdata <= rdata_nxt;
      end
   end

   // ***************************************************************
   // continuous outputs; consumer forms base*mult*num/den
   // ***************************************************************
   // lower address carries the high byte
   assign o_input2_rate.input_base_rate_hz    = {byte_r[0], byte_r[1]};
   assign o_input2_rate.base_rate_multiplier  = {byte_r[2], byte_r[3]};
   assign o_input2_rate.fec_ratio_numerator   = {byte_r[4], byte_r[5]};
   assign o_input2_rate.fec_ratio_denominator = {byte_r[6], byte_r[7]};
   assign o_input3_base_rate                  = {byte_r[8], byte_r[9]};

   // ***************************************************************
   // assertions
   // ***************************************************************
   sequence s_wr_base_hi;
      req.wr && req.addr == `RFC_OFS_IN2_BASE;
   endsequence

   property p_base_hi_write;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
         s_wr_base_hi |=> o_input2_rate.input_base_rate_hz[15:8] == $past(req.wdata);
   endproperty
   a_base_hi_write: assert property (p_base_hi_write) else $error("base high byte not stored");

   property p_mult_lo_write;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
         (req.wr && req.addr == 8'h23) |=> o_input2_rate.base_rate_multiplier[7:0] == $past(req.wdata);
   endproperty
   a_mult_lo_write: assert property (p_mult_lo_write) else $error("multiplier low byte not stored");

   property p_num_hi_write;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
         (req.wr && req.addr == `RFC_OFS_IN2_FEC) |=> o_input2_rate.fec_ratio_numerator[15:8] == $past(req.wdata);
   endproperty
   a_num_hi_write: assert property (p_num_hi_write) else $error("numerator high byte not stored");

   property p_den_lo_write;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
         (req.wr && req.addr == 8'h27) |=> o_input2_rate.fec_ratio_denominator[7:0] == $past(req.wdata);
   endproperty
   a_den_lo_write: assert property (p_den_lo_write) else $error("denominator low byte not stored");

   property p_in3_hi_write;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
         (req.wr && req.addr == `RFC_OFS_IN3_BASE) |=> o_input3_base_rate[15:8] == $past(req.wdata);
   endproperty
   a_in3_hi_write: assert property (p_in3_hi_write) else $error("input3 high byte not stored");

   property p_read_back;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
         (req.rd && req.addr == 8'h21 && !req.wr) |=> o_rdata == $past(o_input2_rate.input_base_rate_hz[7:0]);
   endproperty
   a_read_back: assert property (p_read_back) else $error("read data mismatch");

   property p_unmapped_zero;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
         (req.rd && req.addr > 8'h29) |=> o_rdata == 8'h00;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

   property p_hold_no_write;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
         !req.wr |=> $stable(o_input2_rate) && $stable(o_input3_base_rate);
   endproperty
   a_hold_no_write: assert property (p_hold_no_write) else $error("value changed without write");

   property p_idle_rdata;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
         !req.rd |=> o_rdata == 8'h00;
   endproperty
   a_idle_rdata: assert property (p_idle_rdata) else $error("read data outside read cycle");

   // ***************************************************************
   // assertions: remaining byte lanes land in their own half
   // ***************************************************************
   // a lane that swapped halves would still pass a whole-word check
   property p_base_lo_write;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
         (req.wr && req.addr == 8'h21) |=> o_input2_rate.input_base_rate_hz[7:0] == $past(req.wdata);
   endproperty
   a_base_lo_write: assert property (p_base_lo_write) else $error("base low byte not stored");

   property p_mult_hi_write;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
         (req.wr && req.addr == `RFC_OFS_IN2_MULT) |=> o_input2_rate.base_rate_multiplier[15:8] == $past(req.wdata);
   endproperty
   a_mult_hi_write: assert property (p_mult_hi_write) else $error("multiplier high byte not stored");

   property p_num_lo_write;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
         (req.wr && req.addr == 8'h25) |=> o_input2_rate.fec_ratio_numerator[7:0] == $past(req.wdata);
   endproperty
   a_num_lo_write: assert property (p_num_lo_write) else $error("numerator low byte not stored");

   property p_den_hi_write;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
         (req.wr && req.addr == 8'h26) |=> o_input2_rate.fec_ratio_denominator[15:8] == $past(req.wdata);
   endproperty
   a_den_hi_write: assert property (p_den_hi_write) else $error("denominator high byte not stored");

   property p_in3_lo_write;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
         (req.wr && req.addr == 8'h29) |=> o_input3_base_rate[7:0] == $past(req.wdata);
   endproperty
   a_in3_lo_write: assert property (p_in3_lo_write) else $error("input3 low byte not stored");

   // ***************************************************************
   // assertions: a write touches only its own field
   // ***************************************************************
   // partial updates are visible downstream, so a stray lane would mislead the pll
   sequence s_wr_fec;
      req.wr && req.addr >= `RFC_OFS_IN2_FEC && req.addr <= 8'h27;
   endsequence

   sequence s_wr_unmapped;
      req.wr && (req.addr < `RFC_OFS_IN2_BASE || req.addr > 8'h29);
   endsequence

   property p_base_wr_isolated;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
         s_wr_base_hi |=> $stable(o_input2_rate.base_rate_multiplier) && $stable(o_input3_base_rate);
   endproperty
   a_base_wr_isolated: assert property (p_base_wr_isolated) else $error("base write leaked");

   property p_fec_wr_isolated;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
         s_wr_fec |=> $stable(o_input2_rate.input_base_rate_hz) && $stable(o_input3_base_rate);
   endproperty
   a_fec_wr_isolated: assert property (p_fec_wr_isolated) else $error("fec write leaked");

   property p_den_wr_keeps_num;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
         (req.wr && req.addr == 8'h26) |=> $stable(o_input2_rate.fec_ratio_numerator);
   endproperty
   a_den_wr_keeps_num: assert property (p_den_wr_keeps_num) else $error("denominator write hit numerator");

   property p_wr_unmapped_hold;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
         s_wr_unmapped |=> $stable(o_input2_rate) && $stable(o_input3_base_rate);
   endproperty
   a_wr_unmapped_hold: assert property (p_wr_unmapped_hold) else $error("unmapped write changed a field");

   // ***************************************************************
   // assertions: read lanes and reset values
   // ***************************************************************
   property p_read_base_hi;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
         (req.rd && req.addr == `RFC_OFS_IN2_BASE) |=> o_rdata == $past(o_input2_rate.input_base_rate_hz[15:8]);
   endproperty
   a_read_base_hi: assert property (p_read_base_hi) else $error("base high read mismatch");

   property p_read_mult_hi;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
         (req.rd && req.addr == `RFC_OFS_IN2_MULT) |=> o_rdata == $past(o_input2_rate.base_rate_multiplier[15:8]);
   endproperty
   a_read_mult_hi: assert property (p_read_mult_hi) else $error("multiplier high read mismatch");

   property p_read_mult_lo;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
         (req.rd && req.addr == 8'h23) |=> o_rdata == $past(o_input2_rate.base_rate_multiplier[7:0]);
   endproperty
   a_read_mult_lo: assert property (p_read_mult_lo) else $error("multiplier low read mismatch");

   property p_read_num_hi;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
         (req.rd && req.addr == `RFC_OFS_IN2_FEC) |=> o_rdata == $past(o_input2_rate.fec_ratio_numerator[15:8]);
   endproperty
   a_read_num_hi: assert property (p_read_num_hi) else $error("numerator high read mismatch");

   property p_read_den_lo;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
         (req.rd && req.addr == 8'h27) |=> o_rdata == $past(o_input2_rate.fec_ratio_denominator[7:0]);
   endproperty
   a_read_den_lo: assert property (p_read_den_lo) else $error("denominator low read mismatch");

   property p_read_in3_hi;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
         (req.rd && req.addr == `RFC_OFS_IN3_BASE) |=> o_rdata == $past(o_input3_base_rate[15:8]);
   endproperty
   a_read_in3_hi: assert property (p_read_in3_hi) else $error("input3 high read mismatch");

   property p_low_unmapped_zero;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
         (req.rd && req.addr < `RFC_OFS_IN2_BASE) |=> o_rdata == 8'h00;
   endproperty
   a_low_unmapped_zero: assert property (p_low_unmapped_zero) else $error("low unmapped read not zero");

   // no disable here: the check sits on the first edge after release
   property p_rst_defaults;
      @(posedge i_ref_clk)
         $rose(i_rst_b) |-> o_input2_rate == {`RFC_RST_BASE, `RFC_RST_MULT, `RFC_RST_FEC}
                            && o_input3_base_rate == `RFC_RST_BASE;
   endproperty
   a_rst_defaults: assert property (p_rst_defaults) else $error("fields not at defaults after reset");

   property p_rst_rdata_zero;
      @(posedge i_ref_clk)
         $rose(i_rst_b) |-> o_rdata == 8'h00;
   endproperty
   a_rst_rdata_zero: assert property (p_rst_rdata_zero) else $error("read data not zero after reset");

endmodule // rfc_ref_rate_regs
